// >>> verilog/vpsc_top.sv
// Top: vector arbiter, low-voltage control, reset hold and clock output
//
// Summary of operation
// - Vectors ranked by number, pairs FFE4 to FFFE
// - Reset vector highest, shared by eight causes
// - Detector works only while enable is one
// - Stop disables detector unless stop-enable set
// - Both enables set: deep stop becomes light
// - Power-on resets, held while supply low and detector enabled
// - Power-on sets both flags; low-volt sets one
// - Reset enable makes low-volt detection reset
// - Threshold chosen by one select bit
// - Low-volt reset held until supply recovers
// - Warning with enable sets flag, requests vector 3
// - Select all zero keeps clock output off
// - Nonzero select drives pin, overrides direction
// - Select value sets the division ratio
// - Flagged source requests only if enabled, except vector 1
// - High address byte first, low byte next
`timescale 1ns/1ns
`default_nettype none
module vpsc_top #(
  parameter int unsigned NVEC = 14,
  parameter int unsigned SEL_W = 3
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Analog detector and power-on inputs (asynchronous)
  input wire logic power_on_ind,
  input wire logic below_low_thr,
  input wire logic below_high_thr,
  input wire logic below_warn,
  // Other reset causes, one-cycle pulses on sys_clk
  input wire logic watchdog_reset_cause,
  input wire logic clock_loss_reset_cause,
  input wire logic ext_reset_pin,
  input wire logic bad_opcode_reset_cause,
  input wire logic bad_address_reset_cause,
  input wire logic debug_forced_reset_cause,
  // Peripheral interrupt flags for vectors 1..13
  input wire logic [NVEC-1:0] source_flag,
  // Stop mode request from the core
  input wire logic stop_req,
  input wire logic stop_deep,
  output logic stop_enter,
  output logic stop_light,
  output logic detector_active,
  output logic threshold_high,
  // CPU side
  output logic system_reset,
  output logic irq_valid,
  output logic [3:0] irq_vector,
  output logic [15:0] irq_vector_addr,
  output logic irq_out,
  // Shared port pin
  input wire logic port_dir_out,
  input wire logic port_data,
  output logic shared_clock_out_pin,
  output logic shared_pin_oe
);
  ////////////////////////////////////////////////////////////////////////
  // Synchronisers for asynchronous analog indications
  logic [2:0] por_s, low_s, high_s, warn_s; // Three stages each
  logic por_f, low_f, high_f, warn_f; // Filtered levels

  // Shift; a change counts once stages two and three agree
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      por_s <= 3'h0;
      low_s <= 3'h0;
      high_s <= 3'h0;
      warn_s <= 3'h0;
    end else begin
      por_s <= {por_s[1:0], power_on_ind};
      low_s <= {low_s[1:0], below_low_thr};
      high_s <= {high_s[1:0], below_high_thr};
      warn_s <= {warn_s[1:0], below_warn};
    end
  end

  // Filtered level updates only on agreement
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      por_f <= 1'b0;
      low_f <= 1'b0;
      high_f <= 1'b0;
      warn_f <= 1'b0;
    end else begin
      if (por_s[1] == por_s[2]) por_f <= por_s[2];
      if (low_s[1] == low_s[2]) low_f <= low_s[2];
      if (high_s[1] == high_s[2]) high_f <= high_s[2];
      if (warn_s[1] == warn_s[2]) warn_f <= warn_s[2];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers
  logic det_en, stop_en, rst_en, thr_sel, warn_ie, warn_flag; // Power control
  logic [7:0] reset_cause; // Cause of last reset
  logic [2:0] int_status; // Sticky events
  logic [2:0] int_mask; // Gate for irq_out
  logic [SEL_W-1:0] clk_sel; // Clock output divide select
  logic [NVEC-1:0] src_en; // Local enables, bits 0, 1 and 3 unused
  logic in_stop; // Stop mode in force
  logic hold_low_volt; // Low-voltage reset hold
  logic rd_q; // Read strobe delayed
  logic [7:0] rd_addr_q; // Read address delayed

  // Decode
  wire wr_pwr = reg_wr && (reg_addr == vpsc_pkg::OFS_PWR_CTRL);
  wire wr_clk = reg_wr && (reg_addr == vpsc_pkg::OFS_CLK_OUT);
  wire wr_mask = reg_wr && (reg_addr == vpsc_pkg::OFS_INT_MASK);
  wire wr_en = reg_wr && (reg_addr == vpsc_pkg::OFS_SRC_ENABLE);
  wire rd_status = reg_rd && (reg_addr == vpsc_pkg::OFS_INT_STATUS);
  wire warn_ack = wr_pwr && reg_wdata[vpsc_pkg::PWR_WARN_ACK_BIT];

  ////////////////////////////////////////////////////////////////////////
  // Low-voltage detector control
  // Detector runs only while enabled, and in stop only if allowed
  assign detector_active = det_en && (!in_stop || stop_en);
  assign threshold_high = thr_sel;
  // Below the selected trip level
  wire below_sel = thr_sel ? high_f : low_f;
  wire low_volt_event = detector_active && below_sel;
  wire warn_event = detector_active && warn_f && warn_ie;
  // Power-on still pending or, with detector enabled, supply below low threshold
  wire por_hold = por_f || (det_en && low_f);
  wire lv_reset = low_volt_event && rst_en;

  // Stop demotion: deep becomes light when detector kept alive
  wire demote = det_en && stop_en;
  vpsc_pkg::vpsc_stop_t stop_kind;
  always_comb begin
    stop_kind = vpsc_pkg::VPSC_STOP_NONE;
    if (stop_req) begin
      if (stop_deep && !demote) stop_kind = vpsc_pkg::VPSC_STOP_DEEP;
      else stop_kind = vpsc_pkg::VPSC_STOP_LIGHT;
    end
  end
  assign stop_enter = stop_req;
  assign stop_light = (stop_kind == vpsc_pkg::VPSC_STOP_LIGHT);

  // Stop state; any interrupt or reset wakes
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) in_stop <= 1'b0;
    else if (system_reset || irq_valid) in_stop <= 1'b0;
    else if (stop_req) in_stop <= 1'b1;
  end

  // Hold after low-volt reset until above the selected level
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) hold_low_volt <= 1'b0;
    else if (lv_reset) hold_low_volt <= 1'b1;
    else if (!below_sel) hold_low_volt <= 1'b0;
  end

  // Pulsed reset causes from logic on this clock
  wire pulse_cause = watchdog_reset_cause || clock_loss_reset_cause || ext_reset_pin ||
                     bad_opcode_reset_cause || bad_address_reset_cause ||
                     debug_forced_reset_cause;
  // All causes share vector 0
  assign system_reset = por_hold || lv_reset || hold_low_volt || pulse_cause;

  // Cause register; debug-forced reset sets none of the bits
  logic [7:0] next_cause;
  always_comb begin
    next_cause = reset_cause;
    if (por_f) begin
      next_cause = 8'h00;
      next_cause[vpsc_pkg::RC_POWER_ON] = 1'b1;
      next_cause[vpsc_pkg::RC_LOW_VOLT] = 1'b1;
    end else if (lv_reset) begin
      next_cause = 8'h00;
      next_cause[vpsc_pkg::RC_LOW_VOLT] = 1'b1;
    end else if (debug_forced_reset_cause) begin
      next_cause = 8'h00;
    end else if (pulse_cause) begin
      next_cause = 8'h00;
      next_cause[vpsc_pkg::RC_WDOG] = watchdog_reset_cause;
      next_cause[vpsc_pkg::RC_CLK_LOSS] = clock_loss_reset_cause;
      next_cause[vpsc_pkg::RC_PIN] = ext_reset_pin;
      next_cause[vpsc_pkg::RC_BAD_OP] = bad_opcode_reset_cause;
      next_cause[vpsc_pkg::RC_BAD_ADDR] = bad_address_reset_cause;
    end
  end

  // Cause and power control registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reset_cause <= vpsc_pkg::RESET_CAUSE_RESET;
      {warn_ie, thr_sel, rst_en, stop_en, det_en} <= vpsc_pkg::PWR_CTRL_RESET[4:0];
    end else begin
      reset_cause <= next_cause;
      if (wr_pwr) begin
        det_en <= reg_wdata[vpsc_pkg::PWR_DET_EN_BIT];
        stop_en <= reg_wdata[vpsc_pkg::PWR_STOP_EN_BIT];
        rst_en <= reg_wdata[vpsc_pkg::PWR_RST_EN_BIT];
        thr_sel <= reg_wdata[vpsc_pkg::PWR_THR_SEL_BIT];
        warn_ie <= reg_wdata[vpsc_pkg::PWR_WARN_IE_BIT];
      end
    end
  end

  // Warning flag: set beats acknowledge
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) warn_flag <= 1'b0;
    else if (warn_event) warn_flag <= 1'b1;
    else if (warn_ack) warn_flag <= 1'b0;
  end

  // Other control registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_sel <= vpsc_pkg::CLK_SEL_RESET;
      int_mask <= vpsc_pkg::INT_MASK_RESET;
      src_en <= vpsc_pkg::SRC_ENABLE_RESET;
    end else begin
      if (wr_clk) clk_sel <= reg_wdata[SEL_W-1:0];
      if (wr_mask) int_mask <= reg_wdata[2:0];
      if (wr_en) src_en <= reg_wdata[NVEC-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Vector arbiter
  logic [NVEC-1:0] req; // Enabled requests per vector
  always_comb begin
    req = source_flag & src_en;
    req[vpsc_pkg::VEC_RESET] = 1'b0;
    req[vpsc_pkg::VEC_SWI] = source_flag[vpsc_pkg::VEC_SWI]; // No local enable
    req[vpsc_pkg::VEC_LOW_VOLT] = warn_flag && warn_ie;
  end

  // Lowest number wins; reset trumps all
  logic [3:0] win; // Winning vector
  logic any_req;
  always_comb begin
    win = 4'h0;
    any_req = 1'b0;
    for (int i = NVEC - 1; i >= 1; i--) begin
      if (req[i]) begin
        win = 4'(i);
        any_req = 1'b1;
      end
    end
    if (system_reset) begin
      win = vpsc_pkg::VEC_RESET;
      any_req = 1'b1;
    end
  end

  // High byte at top minus two per vector; low byte follows
  wire [15:0] win_addr = vpsc_pkg::VEC_TOP_HIGH_ADDR - {11'h000, win, 1'b0};

  // Registered vector presented to the CPU, which does the masking
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_valid <= 1'b1;
      irq_vector <= vpsc_pkg::VEC_RESET;
      irq_vector_addr <= vpsc_pkg::VEC_TOP_HIGH_ADDR;
    end else begin
      irq_valid <= any_req;
      irq_vector <= win;
      irq_vector_addr <= win_addr;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sticky interrupt status; a read clears, a new event wins
  // Events of this cycle, placed by status bit position
  logic [2:0] events;
  always_comb begin
    events = 3'h0;
    events[vpsc_pkg::IS_WARN] = warn_event;
    events[vpsc_pkg::IS_RESET_REQ] = lv_reset;
    events[vpsc_pkg::IS_STOP_DEMOTE] = stop_req && stop_deep && demote;
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) int_status <= 3'h0;
    else if (rd_status) int_status <= events;
    else int_status <= int_status | events;
  end
  assign irq_out = |(int_status & int_mask);

  ////////////////////////////////////////////////////////////////////////
  // Clock output on the shared pin
  logic div_clk, div_active;
  vpsc_clk_div #(.SEL_W(SEL_W)) u_div (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .sel(clk_sel),
    .clk_out(div_clk),
    .active(div_active)
  );
  // Clock overrides the port direction when active
  assign shared_clock_out_pin = div_active ? div_clk : port_data;
  assign shared_pin_oe = div_active || port_dir_out;

  ////////////////////////////////////////////////////////////////////////
  // Read data, one cycle after the strobe, zero elsewhere
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_q <= 1'b0;
      rd_addr_q <= 8'h00;
    end else begin
      rd_q <= reg_rd;
      rd_addr_q <= reg_addr;
    end
  end

  // Status snapshot for the read clear
  logic [2:0] status_q;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) status_q <= 3'h0;
    else status_q <= int_status;
  end

  wire [31:0] pwr_word = {25'h0, 1'b0, warn_flag, warn_ie, thr_sel, rst_en, stop_en, det_en};
  always_comb begin
    reg_rdata = 32'h0000_0000;
    if (rd_q) begin
      case (rd_addr_q)
        vpsc_pkg::OFS_PWR_CTRL: reg_rdata = pwr_word;
        vpsc_pkg::OFS_RESET_CAUSE: reg_rdata = {24'h0, reset_cause};
        vpsc_pkg::OFS_INT_STATUS: reg_rdata = {29'h0, status_q};
        vpsc_pkg::OFS_INT_MASK: reg_rdata = {29'h0, int_mask};
        vpsc_pkg::OFS_CLK_OUT: reg_rdata = {{(32-SEL_W){1'b0}}, clk_sel};
        vpsc_pkg::OFS_SRC_ENABLE: reg_rdata = {{(32-NVEC){1'b0}}, src_en};
        vpsc_pkg::OFS_VECTOR: reg_rdata = {irq_vector_addr, 11'h0, irq_valid, irq_vector};
        default: reg_rdata = 32'h0000_0000;
      endcase
    end
  end
endmodule
`default_nettype wire

// >>> verilog/vpsc_pkg.sv
// Package: constants for the vector priority and system control block
package vpsc_pkg;
  // Vector numbers
  localparam int unsigned NUM_VECTORS = 14;
  localparam logic [3:0] VEC_RESET = 4'h0;
  localparam logic [3:0] VEC_SWI = 4'h1;
  localparam logic [3:0] VEC_PIN = 4'h2;
  localparam logic [3:0] VEC_LOW_VOLT = 4'h3;
  localparam logic [3:0] VEC_PLL_UNLOCK = 4'h4;
  // Top of vector space; vector n high byte at base - 2n
  localparam logic [15:0] VEC_TOP_HIGH_ADDR = 16'hFFFE;
  localparam logic [15:0] VEC_BOTTOM_HIGH_ADDR = 16'hFFE4;
  // Register offsets (byte addresses)
  localparam logic [7:0] OFS_PWR_CTRL = 8'h00;
  localparam logic [7:0] OFS_RESET_CAUSE = 8'h04;
  localparam logic [7:0] OFS_INT_STATUS = 8'h08;
  localparam logic [7:0] OFS_INT_MASK = 8'h0C;
  localparam logic [7:0] OFS_CLK_OUT = 8'h10;
  localparam logic [7:0] OFS_SRC_ENABLE = 8'h14;
  localparam logic [7:0] OFS_VECTOR = 8'h18;
  // Power control field positions
  localparam int unsigned PWR_DET_EN_BIT = 0;
  localparam int unsigned PWR_STOP_EN_BIT = 1;
  localparam int unsigned PWR_RST_EN_BIT = 2;
  localparam int unsigned PWR_THR_SEL_BIT = 3;
  localparam int unsigned PWR_WARN_IE_BIT = 4;
  localparam int unsigned PWR_WARN_FLAG_BIT = 5;
  localparam int unsigned PWR_WARN_ACK_BIT = 6;
  // Reset cause field positions
  localparam int unsigned RC_WDOG = 0;
  localparam int unsigned RC_CLK_LOSS = 1;
  localparam int unsigned RC_LOW_VOLT = 2;
  localparam int unsigned RC_PIN = 3;
  localparam int unsigned RC_BAD_OP = 4;
  localparam int unsigned RC_BAD_ADDR = 5;
  localparam int unsigned RC_POWER_ON = 6;
  localparam int unsigned RC_DEBUG = 7;
  // Reset values
  localparam logic [6:0] PWR_CTRL_RESET = 7'h1D;
  localparam logic [7:0] RESET_CAUSE_RESET = 8'h44;
  localparam logic [2:0] CLK_SEL_RESET = 3'h0;
  localparam logic [13:0] SRC_ENABLE_RESET = 14'h0000;
  localparam logic [2:0] INT_MASK_RESET = 3'h0;
  // Interrupt status bits
  localparam int unsigned IS_WARN = 0;
  localparam int unsigned IS_RESET_REQ = 1;
  localparam int unsigned IS_STOP_DEMOTE = 2;
  // Stop request decision
  typedef enum logic [1:0] {
    VPSC_STOP_NONE,
    VPSC_STOP_LIGHT,
    VPSC_STOP_DEEP
  } vpsc_stop_t;
endpackage

// >>> verilog/vpsc_clk_div.sv
// Divided bus clock output for the shared port pin
`timescale 1ns/1ns
`default_nettype none
module vpsc_clk_div #(
  parameter int unsigned SEL_W = 3
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [SEL_W-1:0] sel,
  output logic clk_out,
  output logic active
);
  // Half period in bus cycles equals the select value
  logic [SEL_W-1:0] count;
  logic next_clk;
  wire sel_zero = (sel == '0);
  wire at_limit = (count >= sel - 1'b1);

  assign active = ~sel_zero;

  // Free counter; ratio is 2 x select
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
      clk_out <= 1'b0;
    end else if (sel_zero) begin
      count <= '0; // Held low while disabled
      clk_out <= 1'b0;
    end else if (at_limit) begin
      count <= '0;
      clk_out <= next_clk;
    end else begin
      count <= count + 1'b1;
    end
  end

  assign next_clk = ~clk_out;
endmodule
`default_nettype wire

// >>> test/vpsc_top_monitor.sv
// Port-level checker for the vector priority and system control top
`timescale 1ns/1ns
`default_nettype none
module vpsc_top_monitor (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic reg_wr,
  input wire logic power_on_ind,
  input wire logic stop_req,
  input wire logic stop_deep,
  input wire logic stop_enter,
  input wire logic stop_light,
  input wire logic detector_active,
  input wire logic threshold_high,
  input wire logic system_reset,
  input wire logic irq_valid,
  input wire logic [3:0] irq_vector,
  input wire logic [15:0] irq_vector_addr,
  input wire logic port_dir_out,
  input wire logic shared_clock_out_pin,
  input wire logic shared_pin_oe
);
  // One domain, so one clock and one disable for all
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////
  a_vec_addr_map: assert property (
    irq_valid |-> irq_vector_addr == 16'hFFFE - {11'h000, irq_vector, 1'b0})
    else $error("vector address not high byte of pair");
  a_vec_in_range: assert property (
    irq_valid |-> irq_vector <= 4'hD) else $error("vector beyond 13");
  a_reset_wins: assert property (
    system_reset |=> irq_valid && irq_vector == 4'h0) else $error("reset not vector 0");
  a_power_hold: assert property (
    power_on_ind [*6] |-> system_reset) else $error("power-on not resetting");
  a_stop_shallow: assert property (
    stop_req && !stop_deep |-> stop_light) else $error("shallow stop not light");
  a_stop_follow: assert property (
    stop_enter == stop_req) else $error("stop entry not following request");
  a_stop_det_kept: assert property (
    stop_req && stop_deep && stop_light && !reg_wr |=> detector_active)
    else $error("detector dropped in stop despite stop enable");
  // Clock divisor tops out at 7, so a toggle must show within 8
  a_clk_toggles: assert property (
    shared_pin_oe && !port_dir_out |->
      ##[1:8] ($changed(shared_clock_out_pin) || !shared_pin_oe))
    else $error("clock output stalled");
  a_thr_stable: assert property (
    !reg_wr && !system_reset |=> $stable(threshold_high) || system_reset)
    else $error("threshold select moved without write");
endmodule
bind vpsc_top vpsc_top_monitor u_vpsc_top_monitor (.sys_clk(sys_clk), .rst_n(rst_n),
  .reg_wr(reg_wr), .power_on_ind(power_on_ind), .stop_req(stop_req),
  .stop_deep(stop_deep), .stop_enter(stop_enter), .stop_light(stop_light),
  .detector_active(detector_active),
  .threshold_high(threshold_high), .system_reset(system_reset), .irq_valid(irq_valid),
  .irq_vector(irq_vector), .irq_vector_addr(irq_vector_addr), .port_dir_out(port_dir_out),
  .shared_clock_out_pin(shared_clock_out_pin), .shared_pin_oe(shared_pin_oe));
`default_nettype wire

// >>> test/vpsc_cpu_model.sv
// Behavioural core that takes presented vectors
`timescale 1ns/1ns
`default_nettype none
module vpsc_cpu_model (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic global_mask,
  input wire logic system_reset,
  input wire logic irq_valid,
  input wire logic [3:0] irq_vector,
  output logic [3:0] taken_vector
);
  // Fetch only when unmasked and not held in reset
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      taken_vector <= 4'h0;
    end else if (irq_valid && !global_mask && !system_reset) begin
      taken_vector <= irq_vector;
    end
  end
endmodule
`default_nettype wire

// >>> test/tb_vpsc_top.sv
// Self-checking bench for the vector priority and system control top
`timescale 1ns/1ns
`default_nettype none
module tb_vpsc_top;
  logic sys_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic power_on_ind = 1'b0, below_low_thr = 1'b0, below_high_thr = 1'b0, below_warn = 1'b0;
  logic [5:0] cause = 6'h00;
  logic [13:0] source_flag = 14'h0000;
  logic stop_req = 1'b0, stop_deep = 1'b0, port_dir_out = 1'b0, port_data = 1'b1;
  logic stop_enter, stop_light, detector_active, threshold_high, system_reset;
  logic irq_valid, irq_out, shared_clock_out_pin, shared_pin_oe;
  logic [3:0] irq_vector, taken_vector;
  logic [15:0] irq_vector_addr;
  logic [7:0] exp_c [6] = '{8'h01, 8'h02, 8'h08, 8'h10, 8'h20, 8'h00};
  int err_count = 0, comparisons = 0, cycles = 0, n;
  always #4 sys_clk = ~sys_clk;
  vpsc_top u_vpsc_top (.sys_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .power_on_ind, .below_low_thr, .below_high_thr, .below_warn,
    .watchdog_reset_cause(cause[0]), .clock_loss_reset_cause(cause[1]),
    .ext_reset_pin(cause[2]), .bad_opcode_reset_cause(cause[3]),
    .bad_address_reset_cause(cause[4]), .debug_forced_reset_cause(cause[5]),
    .source_flag, .stop_req, .stop_deep, .stop_enter, .stop_light, .detector_active,
    .threshold_high, .system_reset, .irq_valid, .irq_vector, .irq_vector_addr, .irq_out,
    .port_dir_out, .port_data, .shared_clock_out_pin, .shared_pin_oe);
  vpsc_cpu_model u_vpsc_cpu_model (.sys_clk, .rst_n, .global_mask(1'b0), .system_reset,
    .irq_valid, .irq_vector, .taken_vector);
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen_v, input logic [31:0] exp);
    comparisons++;
    if (seen_v !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, seen_v);
    end
  endtask
  // Bus strobes last one cycle, driven just after the edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rdc(input string w, input logic [7:0] a, input logic [31:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 check(w, reg_rdata, e);
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask
  // Drive both thresholds, then release and expect recovery
  task automatic lvr(input logic [31:0] ctrl, input logic h, input logic l, input logic e);
    wr(vpsc_pkg::OFS_PWR_CTRL, ctrl);
    @(posedge sys_clk) {below_high_thr, below_low_thr} <= {h, l};
    cyc(10);
    check("lv_reset", 32'(system_reset), 32'(e));
    @(posedge sys_clk) {below_high_thr, below_low_thr} <= 2'b00;
    cyc(12);
    check("lv_release", 32'(system_reset), 32'h0);
  endtask
  // Cycles until the clock pin next changes, bounded
  task automatic tog(output int k);
    logic p;
    p = shared_clock_out_pin;
    k = 0;
    while (shared_clock_out_pin === p && k < 20) begin
      @(posedge sys_clk);
      #1 k++;
    end
  endtask
  task automatic end_of_test();
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Hang guard, far above the few hundred cycles needed
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      end_of_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    rdc("pwr_ctrl", vpsc_pkg::OFS_PWR_CTRL, 32'h0000_001D);
    rdc("cause_por", vpsc_pkg::OFS_RESET_CAUSE, 32'h0000_0044);
    rdc("unmapped", 8'h1C, 32'h0);
    check("thr_high", 32'(threshold_high), 32'h1);
    $display("Test reset values done");
    wr(vpsc_pkg::OFS_SRC_ENABLE, 32'h0000_3FF4);
    for (int v = 13; v >= 1; v--) begin
      if (v == 3)
        continue;
      @(posedge sys_clk) source_flag <= 14'h3FFF << v;
      cyc(3);
      check("vector", 32'(irq_vector), 32'(v));
      check("vec_addr", 32'(irq_vector_addr), 32'h0000_FFFE - 2 * v);
      check("cpu_take", 32'(taken_vector), 32'(v));
    end
    @(posedge sys_clk) source_flag <= 14'h2000;
    rdc("vec_reg", vpsc_pkg::OFS_VECTOR, 32'hFFE4_001D);
    wr(vpsc_pkg::OFS_SRC_ENABLE, 32'h0);
    cyc(2);
    check("disabled", 32'(irq_valid), 32'h0);
    @(posedge sys_clk) source_flag <= 14'h0000;
    $display("Test vector priority done");
    @(posedge sys_clk) below_warn <= 1'b1;
    cyc(8);
    check("irq_masked", 32'(irq_out), 32'h0);
    check("warn_vec", 32'(irq_vector), 32'h3);
    rdc("warn_flag", vpsc_pkg::OFS_PWR_CTRL, 32'h0000_003D);
    @(posedge sys_clk) below_warn <= 1'b0;
    cyc(6);
    wr(vpsc_pkg::OFS_INT_MASK, 32'h1);
    cyc(1);
    check("irq_out", 32'(irq_out), 32'h1);
    rdc("int_status", vpsc_pkg::OFS_INT_STATUS, 32'h1);
    check("irq_cleared", 32'(irq_out), 32'h0);
    wr(vpsc_pkg::OFS_PWR_CTRL, 32'h0000_000D);
    cyc(2);
    check("warn_off", 32'(irq_valid), 32'h0);
    wr(vpsc_pkg::OFS_PWR_CTRL, 32'h0000_005D);
    rdc("warn_ack", vpsc_pkg::OFS_PWR_CTRL, 32'h0000_001D);
    $display("Test warning interrupt done");
    lvr(32'h0000_001D, 1'b1, 1'b0, 1'b1);
    rdc("cause_lv", vpsc_pkg::OFS_RESET_CAUSE, 32'h0000_0004);
    lvr(32'h0000_0015, 1'b1, 1'b0, 1'b0);
    lvr(32'h0000_0015, 1'b0, 1'b1, 1'b1);
    lvr(32'h0000_0019, 1'b1, 1'b0, 1'b0);
    lvr(32'h0000_001C, 1'b1, 1'b1, 1'b0);
    wr(vpsc_pkg::OFS_PWR_CTRL, 32'h0000_001D);
    @(posedge sys_clk) {power_on_ind, below_low_thr} <= 2'b11;
    cyc(8);
    @(posedge sys_clk) power_on_ind <= 1'b0;
    cyc(8);
    check("por_hold", 32'(system_reset), 32'h1);
    @(posedge sys_clk) below_low_thr <= 1'b0;
    cyc(10);
    check("por_release", 32'(system_reset), 32'h0);
    rdc("cause_por2", vpsc_pkg::OFS_RESET_CAUSE, 32'h0000_0044);
    $display("Test low voltage done");
    for (int i = 0; i < 6; i++) begin
      @(posedge sys_clk) cause <= 6'h01 << i;
      #1 check("cause_reset", 32'(system_reset), 32'h1);
      @(posedge sys_clk) cause <= 6'h00;
      cyc(6);
      rdc("cause_reg", vpsc_pkg::OFS_RESET_CAUSE, 32'(exp_c[i]));
    end
    $display("Test reset causes done");
    @(posedge sys_clk) {stop_req, stop_deep} <= 2'b11;
    #1 check("deep_ok", 32'(stop_light), 32'h0);
    check("stop_enter", 32'(stop_enter), 32'h1);
    @(posedge sys_clk) stop_req <= 1'b0;
    #1 check("det_stop", 32'(detector_active), 32'h0);
    wr(vpsc_pkg::OFS_PWR_CTRL, 32'h0000_001F);
    cyc(1);
    check("det_stop_en", 32'(detector_active), 32'h1);
    @(posedge sys_clk) stop_req <= 1'b1;
    #1 check("demoted", 32'(stop_light), 32'h1);
    @(posedge sys_clk) stop_req <= 1'b0;
    @(posedge sys_clk) {stop_req, stop_deep} <= 2'b10;
    #1 check("shallow", 32'(stop_light), 32'h1);
    @(posedge sys_clk) stop_req <= 1'b0;
    wr(vpsc_pkg::OFS_SRC_ENABLE, 32'h0000_2000);
    @(posedge sys_clk) source_flag <= 14'h2000;
    cyc(3);
    check("wake_vec", 32'(irq_vector), 32'hD);
    @(posedge sys_clk) source_flag <= 14'h0000;
    $display("Test stop modes done");
    @(posedge sys_clk) port_dir_out <= 1'b1;
    #1 check("pin_port", 32'(shared_clock_out_pin), 32'h1);
    @(posedge sys_clk) port_dir_out <= 1'b0;
    #1 check("pin_off", 32'(shared_pin_oe), 32'h0);
    for (int s = 1; s < 8; s++) begin
      wr(vpsc_pkg::OFS_CLK_OUT, 32'(s));
      @(posedge sys_clk) port_dir_out <= s[0];
      tog(n);
      tog(n);
      check("clk_half", 32'(n), 32'(s));
      check("clk_oe", 32'(shared_pin_oe), 32'h1);
    end
    wr(vpsc_pkg::OFS_CLK_OUT, 32'h0);
    $display("Test clock output done");
    end_of_test();
  end
endmodule
`default_nettype wire
